/* File: inc/cmp_pkg.sv */
`default_nettype none
package cmp_pkg;
  // Byte offsets of the AXI4-Lite register map.
  localparam logic [7:0] ctrl_off     = 8'h00;
  localparam logic [7:0] irq_stat_off = 8'h04;
  localparam logic [7:0] irq_clr_off  = 8'h08;
  localparam logic [7:0] irq_en_off   = 8'h0C;
  localparam logic [7:0] core_off     = 8'h10;
  localparam logic [7:0] mirror_off   = 8'h14;
  // Control register field positions.
  localparam int en_bit    = 7;
  localparam int res_bit   = 6;
  localparam int route_bit = 5;
  localparam int pol_bit   = 4;
  localparam int spd_bit   = 3;
  localparam int ref_bit   = 2;
  // Core control bit positions.
  localparam int irq_en_pos  = 0;
  localparam int per_en_pos  = 1;
  localparam int glob_en_pos = 2;
  localparam int sleep_pos   = 3;
  // Reset values.
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [3:0] core_rst = 4'h0;
  localparam logic [1:0] irq_rst  = 2'h0;
  // Status bit positions: comparator flag and wake event.
  localparam int ev_flag = 0;
  localparam int ev_wake = 1;
  // Phase counter: four phases per instruction cycle.
  localparam logic [1:0] phase_q1 = 2'h0;
  localparam logic [1:0] phase_q2 = 2'h1;
  // Wake sequence states.
  typedef enum logic [2:0] {
    st_run   = 3'b001,
    st_sleep = 3'b010,
    st_post  = 3'b100
  } wake_st_t;
  // AXI response codes.
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage
`default_nettype wire

/* File: logic/mismatch_det.sv */
`default_nettype none
// Two-latch mismatch detector with edge-triggered flag pulse.
module mismatch_det
  import cmp_pkg::*;
(
  input  wire logic core_clk,     // System clock.
  input  wire logic srst,         // Synchronous reset.
  input  wire logic q1_tick,      // Sample strobe on phase Q1.
  input  wire logic read_tick,    // Control register read strobe.
  input  wire logic result,       // Polarity-adjusted result.
  output logic      mismatch,     // Mismatch level.
  output logic      mismatch_edge // One-cycle rising-edge pulse.
);
  logic read_latch_r;  // Value captured at the last read.
  logic q1_latch_r;    // Value captured every Q1.
  logic mis_d_r;       // Delayed mismatch for edge detect.

  // A read refreshes the read latch, clearing the mismatch.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      read_latch_r <= 1'b0;
    end else if (read_tick) begin
      read_latch_r <= result;
    end
  end

  // Q1 latch follows the result once per instruction cycle.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q1_latch_r <= 1'b0;
    end else if (q1_tick) begin
      q1_latch_r <= result;
    end
  end

  assign mismatch = read_latch_r ^ q1_latch_r;

  // Edge, not level, makes the flag so a cleared flag stays clear.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mis_d_r <= 1'b0;
    end else begin
      mis_d_r <= mismatch;
    end
  end

  assign mismatch_edge = mismatch & ~mis_d_r;
endmodule
`default_nettype wire

/* File: logic/cmp_ctrl.sv */
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
// Control, interrupt and wake logic around one comparator.
module cmp_ctrl
  import cmp_pkg::*;
(
  input  wire logic        core_clk,    // System clock, 10 MHz.
  input  wire logic        srst,        // Synchronous active-high reset.
  input  wire logic [7:0]  s_awaddr,    // AXI write address.
  input  wire logic        s_awvalid,   // AXI write address valid.
  output logic             s_awready,   // AXI write address ready.
  input  wire logic [31:0] s_wdata,     // AXI write data.
  input  wire logic [3:0]  s_wstrb,     // AXI write strobes.
  input  wire logic        s_wvalid,    // AXI write data valid.
  output logic             s_wready,    // AXI write data ready.
  output logic [1:0]       s_bresp,     // AXI write response.
  output logic             s_bvalid,    // AXI write response valid.
  input  wire logic        s_bready,    // AXI write response ready.
  input  wire logic [7:0]  s_araddr,    // AXI read address.
  input  wire logic        s_arvalid,   // AXI read address valid.
  output logic             s_arready,   // AXI read address ready.
  output logic [31:0]      s_rdata,     // AXI read data.
  output logic [1:0]       s_rresp,     // AXI read response.
  output logic             s_rvalid,    // AXI read data valid.
  input  wire logic        s_rready,    // AXI read data ready.
  input  wire logic        cmp_raw,     // Raw analog comparator output.
  input  wire logic        pin_direction_bit, // Pin direction, 0 = output.
  output logic             cmp_power_on,      // Analog comparator powered.
  output logic             speed_power_select, // 1 normal, 0 low power.
  output logic             reference_select,   // 1 internal reference.
  output logic [1:0]       inverting_input_select, // Inverting pin code.
  output logic             vref_enable,  // Voltage reference powered.
  output logic             pin_out,      // Comparator pin level.
  output logic             pin_oe_n,     // Pin drive enable, low drives.
  output logic             wake_req,     // Core wake pulse.
  output logic             run_next_instr, // Execute post-sleep instruction.
  output logic             isr_vector,   // Go to service routine.
  output logic             irq           // Level interrupt.
);
  logic [7:0] comparator_control_reg; // Writable control bits.
  logic [3:0] core_ctrl_r;            // Enables and sleep request.
  logic [1:0] irq_stat_r;             // Sticky events.
  logic [1:0] irq_en_r;               // Event enables.
  logic       raw_s1_r;               // First synchroniser stage.
  logic       raw_s2_r;               // Second synchroniser stage.
  logic [1:0] phase_r;                // Instruction phase counter.
  logic       result;                 // Polarity-adjusted result.
  logic       mismatch;               // Mismatch level.
  logic       mismatch_edge;          // Mismatch rising edge.
  logic       read_tick;              // Control register read strobe.
  logic       q1_tick;                // Phase Q1 strobe.
  wake_st_t   st_r;                   // Wake sequence state.
  wake_st_t   st_nxt;                 // Next wake state.
  logic       aw_r;                   // Write address held.
  logic       w_r;                    // Write data held.
  logic [7:0] awaddr_r;               // Held write address.
  logic [31:0] wdata_r;               // Held write data.
  logic [3:0] wstrb_r;                // Held write strobes.
  logic       do_write;               // Both halves present.
  logic       do_read;                // Read address taken.
  logic [31:0] rd_mux;                // Read data selection.
  logic       rd_hit;                 // Read address mapped.
  logic       wr_hit;                 // Write address mapped.
  logic       comparator_irq_flag;    // Comparator flag view.

  // Decode whether an address is one of ours.
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ctrl_off) || (a == irq_stat_off) || (a == irq_clr_off) ||
                  (a == irq_en_off) || (a == core_off) || (a == mirror_off);
  endfunction

  // Pin input crosses into our clock through two flip-flops.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      raw_s1_r <= 1'b0;
      raw_s2_r <= 1'b0;
    end else begin
      raw_s1_r <= cmp_raw;
      raw_s2_r <= raw_s1_r;
    end
  end

  // Four-phase counter models the instruction cycle.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_r <= phase_q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign q1_tick = (phase_r == phase_q1);

  // When off, polarity alone sets the result, so latches can be preset.
  assign result = (comparator_control_reg[en_bit] & raw_s2_r)
                  ^ comparator_control_reg[pol_bit];

  // Analog controls follow the register directly; sleep is not a term.
  assign cmp_power_on           = comparator_control_reg[en_bit];
  assign speed_power_select     = comparator_control_reg[spd_bit];
  assign reference_select       = comparator_control_reg[ref_bit];
  assign inverting_input_select = comparator_control_reg[1:0];
  assign vref_enable            = comparator_control_reg[en_bit] &
                                  comparator_control_reg[ref_bit];

  // Pin output needs route, enable and output direction together.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= result;
      pin_oe_n <= ~(comparator_control_reg[route_bit] &
                    comparator_control_reg[en_bit] & ~pin_direction_bit);
    end
  end

  // Any control access reads first; reads on Q1 load at the same edge
  // as the Q1 sample, so a change there can be swallowed.
  assign read_tick = ((do_read && s_araddr == ctrl_off) ||
                      (do_write && awaddr_r == ctrl_off));

  mismatch_det u_mis (
    .core_clk      (core_clk),
    .srst          (srst),
    .q1_tick       (q1_tick),
    .read_tick     (read_tick),
    .result        (result),
    .mismatch      (mismatch),
    .mismatch_edge (mismatch_edge)
  );

  // AXI write channels: each half is held until both are present.
  assign s_awready = ~aw_r & ~s_bvalid;
  assign s_wready  = ~w_r & ~s_bvalid;
  assign do_write  = aw_r & w_r;
  assign wr_hit    = addr_mapped(awaddr_r);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_r     <= 1'b0;
      w_r      <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_r     <= 1'b1;
        awaddr_r <= s_awaddr;
      end else if (do_write) begin
        aw_r <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_r     <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end else if (do_write) begin
        w_r <= 1'b0;
      end
    end
  end

  // Write response follows the completed write.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_bvalid <= 1'b0;
      s_bresp  <= resp_okay;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_hit ? resp_okay : resp_slverr;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Control register: result bit is never stored, it reads live.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      comparator_control_reg <= ctrl_rst;
    end else if (do_write && awaddr_r == ctrl_off && wstrb_r[0]) begin
      comparator_control_reg <= {wdata_r[7], 1'b0, wdata_r[5:0]};
    end
  end

  // Core control: interrupt enables and the sleep request.
  // A write that lands in the wake cycle keeps its enables; only the
  // sleep request is dropped, because the core is awake from then on.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      core_ctrl_r <= core_rst;
    end else begin
      if (do_write && awaddr_r == core_off && wstrb_r[0]) begin
        core_ctrl_r <= wdata_r[3:0];
      end
      if (wake_req) begin
        core_ctrl_r[sleep_pos] <= 1'b0;
      end
    end
  end

  // Event enables.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_en_r <= irq_rst;
    end else if (do_write && awaddr_r == irq_en_off && wstrb_r[0]) begin
      irq_en_r <= wdata_r[1:0];
    end
  end

  // Sticky events: a new event wins over a clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_stat_r <= irq_rst;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (i == ev_flag && mismatch_edge) begin
          irq_stat_r[i] <= 1'b1;
        end else if (i == ev_wake && wake_req) begin
          irq_stat_r[i] <= 1'b1;
        end else if (do_write && awaddr_r == irq_clr_off && wstrb_r[0] && wdata_r[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  assign comparator_irq_flag = irq_stat_r[ev_flag];

  // Enabled comparator flag is the wake condition.
  logic wake_cond; // Flag with both interrupt enables set.
  assign wake_cond = comparator_irq_flag & core_ctrl_r[irq_en_pos] &
                     core_ctrl_r[per_en_pos];

  // Wake sequence: sleep, then one instruction, then maybe vector.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      st_run: begin
        if (core_ctrl_r[sleep_pos]) begin
          st_nxt = st_sleep;
        end
      end
      st_sleep: begin
        if (wake_cond) begin
          st_nxt = st_post;
        end
      end
      st_post: begin
        st_nxt = st_run;
      end
      default: begin
        st_nxt = st_run;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= st_run;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wake_req       = (st_r == st_sleep) && (st_nxt == st_post);
  assign run_next_instr = (st_r == st_post);
  // Vectoring waits until the post-sleep instruction is done.
  assign isr_vector = (st_r == st_run) && wake_cond && core_ctrl_r[glob_en_pos];

  assign irq = |(irq_stat_r & irq_en_r);

  // Read data selection.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_araddr)
      ctrl_off: begin
        rd_mux[7:0] = comparator_control_reg;
        rd_mux[res_bit] = result;
      end
      irq_stat_off: begin
        rd_mux[1:0] = irq_stat_r;
      end
      irq_en_off: begin
        rd_mux[1:0] = irq_en_r;
      end
      core_off: begin
        rd_mux[3:0] = core_ctrl_r;
      end
      mirror_off: begin
        rd_mux[0] = result;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  assign rd_hit    = addr_mapped(s_araddr);
  assign s_arready = ~s_rvalid;
  assign do_read   = s_arvalid & s_arready;

  // Read answer registers one cycle after the address is taken.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= resp_okay;
    end else if (do_read) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_mux;
      s_rresp  <= rd_hit ? resp_okay : resp_slverr;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/cmp_ctrl_properties.sv */
`default_nettype none
// Port-level checks of the comparator control block.
module cmp_ctrl_checker
  import cmp_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic pin_direction_bit,
  input wire logic cmp_power_on,
  input wire logic reference_select,
  input wire logic vref_enable,
  input wire logic pin_oe_n,
  input wire logic wake_req,
  input wire logic run_next_instr,
  input wire logic isr_vector,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // Both write halves taken at one edge.
  sequence aw_hs;
    s_awvalid && s_awready;
  endsequence
  sequence w_hs;
    s_wvalid && s_wready;
  endsequence
  // One cycle of the following instruction, then back to run.
  sequence post_step;
    run_next_instr ##1 !run_next_instr;
  endsequence
  reset_off_a: assert property ($fell(srst) |-> !cmp_power_on && !vref_enable && pin_oe_n && !irq)
    else $error("Outputs not off after reset.");
  vref_tie_a: assert property (vref_enable == (cmp_power_on && reference_select))
    else $error("Reference power mismatch.");
  pin_drive_a: assert property (!pin_oe_n |-> $past(cmp_power_on) && !$past(pin_direction_bit))
    else $error("Pin driven while not allowed.");
  wake_seq_a: assert property (wake_req |=> post_step)
    else $error("Post-sleep step missing.");
  post_no_isr_a: assert property (run_next_instr |-> !isr_vector)
    else $error("Vector before post-sleep step.");
  wr_resp_a: assert property (aw_hs ##0 w_hs |-> ##[1:2] s_bvalid)
    else $error("Write response late.");
  wr_refuse_a: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("Write taken during response.");
  rd_resp_a: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("Read data late.");
  rd_refuse_a: assert property (s_rvalid |-> !s_arready)
    else $error("Read taken during response.");
  wake_seen_c: cover property (wake_req);
endmodule
bind cmp_ctrl cmp_ctrl_checker cmp_ctrl_checker_i (.*);
`default_nettype wire

/* File: tb/analog_front.sv */
`default_nettype none
// Behavioural analog side: input muxes and the comparator itself.
module analog_front
(
  input  wire logic        core_clk,
  input  wire logic        cmp_power_on,
  input  wire logic        speed_power_select,
  input  wire logic        reference_select,
  input  wire logic [1:0]  inverting_input_select,
  input  wire logic        vref_enable,
  input  wire logic [7:0]  pin_p,   // Non-inverting pin level.
  input  wire logic [31:0] pins_n,  // Four inverting pin levels, 8 bits each.
  input  wire logic [7:0]  vref_lv, // Internal reference level.
  output logic             cmp_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] vp;
  logic [7:0] vn;
  logic       fast;
  logic       slow_r;
  logic       junk_r;
  assign vp = reference_select ? (vref_enable ? vref_lv : 8'h00) : pin_p;
  assign vn = pins_n[inverting_input_select*8 +: 8];
  assign fast = vp > vn;
  // Low power mode answers one cycle later; an unpowered stage toggles, not holds.
  always_ff @(posedge core_clk) begin
    slow_r <= fast;
    junk_r <= (junk_r === 1'b0); // Leaves the unknown start level at once.
  end
  assign cmp_raw = cmp_power_on ? (speed_power_select ? fast : slow_r) : junk_r;
endmodule
`default_nettype wire

/* File: tb/test_comparator_control_wake_logic.sv */
`default_nettype none
// Self-checking bench: registers, pin, interrupt and wake from sleep.
module test_comparator_control_wake_logic
  import cmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, srst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic s_arvalid, s_arready, s_rvalid, cmp_raw, pin_dir, cmp_power_on;
  logic speed_power_select, reference_select, vref_enable, pin_out, pin_oe_n;
  logic wake_req, run_next_instr, isr_vector, irq;
  logic [1:0]  s_bresp, s_rresp, inverting_input_select, resp;
  logic [7:0]  s_awaddr, s_araddr, pin_p, vref_lv, v;
  logic [31:0] s_wdata, s_rdata, pins_n, d;
  int          err_count, checks_done, seed, i;
  cmp_ctrl cmp_ctrl_i (.core_clk(core_clk), .srst(srst), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(1'b1), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(1'b1),
    .cmp_raw(cmp_raw), .pin_direction_bit(pin_dir), .cmp_power_on(cmp_power_on),
    .speed_power_select(speed_power_select), .reference_select(reference_select),
    .inverting_input_select(inverting_input_select), .vref_enable(vref_enable),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .wake_req(wake_req),
    .run_next_instr(run_next_instr), .isr_vector(isr_vector), .irq(irq));
  analog_front analog_front_i (.core_clk(core_clk), .cmp_power_on(cmp_power_on),
    .speed_power_select(speed_power_select), .reference_select(reference_select),
    .inverting_input_select(inverting_input_select), .vref_enable(vref_enable),
    .pin_p(pin_p), .pins_n(pins_n), .vref_lv(vref_lv), .cmp_raw(cmp_raw));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Expected result bit: raw comparison adjusted by polarity, polarity alone when off.
  function automatic logic exp_res(input logic [7:0] c);
    logic [7:0] vp;
    vp = c[ref_bit] ? vref_lv : pin_p;
    return c[en_bit] ? ((vp > pins_n[c[1:0]*8 +: 8]) ^ c[pol_bit]) : c[pol_bit];
  endfunction
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    err_count++;
    $display("ERROR %0t: wait ran out", $time);
    test_done();
  endtask
  // Ready is combinational, so its level at the falling edge is the one taken at the next rise.
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic aw_ok, w_ok, b_ok;
    int   n;
    n = 0;
    b_ok = 1'b0;
    s_awaddr <= a;
    s_wdata <= dt;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!b_ok && n < 40) begin
      @(negedge core_clk);
      aw_ok = s_awvalid && s_awready;
      w_ok = s_wvalid && s_wready;
      b_ok = s_bvalid;
      resp = s_bresp;
      @(posedge core_clk);
      if (aw_ok) s_awvalid <= 1'b0;
      if (w_ok) s_wvalid <= 1'b0;
      n++;
    end
    if (!b_ok) timeout();
  endtask
  task automatic rd(input logic [7:0] a);
    logic r_ok, ar_ok;
    int   n;
    n = 0;
    r_ok = 1'b0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    while (!r_ok && n < 40) begin
      @(negedge core_clk);
      ar_ok = s_arvalid && s_arready;
      r_ok = s_rvalid;
      d = s_rdata;
      resp = s_rresp;
      @(posedge core_clk);
      if (ar_ok) s_arvalid <= 1'b0;
      n++;
    end
    if (!r_ok) timeout();
  endtask
  // Waits at falling edges for the interrupt (0) or the wake pulse (1).
  task automatic wait_hi(input int which);
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      if ((which == 1) ? wake_req : irq) break;
    end
    if (n == 40) timeout();
  endtask
  initial begin
    seed = 79;
    {srst, s_awvalid, s_wvalid, s_arvalid, pin_dir} = 5'b10001;
    {s_awaddr, s_araddr, s_wdata} = '0;
    {pin_p, vref_lv, pins_n} = {8'h10, 8'h80, 32'h40C0_2080};
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    foreach (v[k]) begin
      rd(ctrl_off + 8'(k / 2 * 4));
      chk(d, 32'h0);
    end
    // Random control values, every inverting select code twice.
    for (i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      v[1:0] = 2'(i);
      pin_p <= 8'($random(seed));
      wr(ctrl_off, {24'h0, v});
      repeat (10) @(posedge core_clk);
      rd(ctrl_off);
      chk(d, {24'h0, v[7], exp_res(v), v[5:0]});
      rd(mirror_off);
      chk(d, {31'h0, exp_res(v)});
      chk(32'({cmp_power_on, speed_power_select, reference_select, inverting_input_select,
        vref_enable}), 32'({v[7], v[3], v[2], v[1:0], v[7] & v[2]}));
    end
    // Routed result drives the pin only as output.
    pin_dir <= 1'b0;
    wr(ctrl_off, 32'hA0);
    // Pin levels are looked at mid-cycle, away from the edge that launches them.
    repeat (10) @(negedge core_clk);
    chk({pin_oe_n, pin_out}, {1'b0, exp_res(8'hA0)});
    pin_dir <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk(pin_oe_n, 1'b1);
    @(posedge core_clk);
    pin_p <= 8'h10;
    pins_n <= 32'h0000_0080;
    wr(ctrl_off, 32'h88);
    repeat (10) @(posedge core_clk); // Bias settling before arming.
    chk(pin_oe_n, 1'b1);
    rd(ctrl_off);
    wr(irq_clr_off, 32'h3);
    wr(irq_en_off, 32'h1);
    chk(irq, 1'b0);
    pin_p <= 8'hFF;
    wait_hi(0);
    @(posedge core_clk);
    rd(irq_stat_off);
    chk(d[0], 1'b1);
    // Mismatch level persists, but a cleared flag must not return.
    wr(irq_clr_off, 32'h1);
    repeat (20) @(posedge core_clk);
    chk(irq, 1'b0);
    rd(ctrl_off);
    wr(irq_en_off, 32'h0);
    pin_p <= 8'h10;
    repeat (20) @(posedge core_clk);
    rd(irq_stat_off);
    chk({irq, d[0]}, 2'b01);
    rd(ctrl_off);
    wr(irq_clr_off, 32'h3);
    wr(core_off, 32'hF);
    pin_p <= 8'hFF;
    wait_hi(1);
    @(negedge core_clk);
    chk(run_next_instr, 1'b1);
    @(negedge core_clk);
    chk(isr_vector, 1'b1);
    @(posedge core_clk);
    rd(core_off);
    chk(d[3], 1'b0);
    rd(irq_stat_off);
    chk(d[1:0], 2'b11);
    // Disabled comparator in sleep is off and cannot wake.
    wr(ctrl_off, 32'h0);
    repeat (10) @(posedge core_clk); // The disable itself is a change; let its flag rise first.
    wr(irq_clr_off, 32'h3);
    wr(core_off, 32'hB);
    pin_p <= 8'h10;
    repeat (20) @(posedge core_clk);
    rd(irq_stat_off);
    chk({cmp_power_on, d[1]}, 2'b00);
    rd(8'h40);
    chk(resp, resp_slverr);
    chk(d, 32'h0);
    wr(8'h40, 32'hFF);
    chk(resp, resp_slverr);
    wr(ctrl_off, 32'hFF);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(ctrl_off);
    chk({cmp_power_on, vref_enable}, 2'b00);
    chk(d, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
